/* File: hw/sfo_supervisor.sv */
// Purpose: Fail outputs with alternate pin roles, reset output and soft reset.
// Assumes: Mode, failure and supply events come synchronous from the chip core.
// Notes: The blinking and dimmed pins are open drain in the fail role.
//
// How it works
// - Pin roles are written only in normal mode; a soft reset in stop also restores their defaults.
// - Sleep keeps normal-mode pin settings; stop keeps them until a soft reset.
// - Fail role activates on failure, stays in fail-safe.
// - Wake role works in restart, off in fail-safe.
// - Switch roles off in restart and fail-safe.
// - Activated fail output persists into normal mode.
// - Blinking output toggles 1.25 Hz, 50 percent.
// - Dimmed output pulses 100 Hz, selectable duty.
// - Test level filtered 64 us before acceptance.
// - Reset low after filter, held plus delay.
// - Power-up reset released delay after supply good.
// - Watchdog failure also asserts reset output.
// - Reset threshold programmable, rewritable in normal mode.
// - Mode code 11 restores defaults, back to init.
// - Option bit selects whether soft reset pulses reset.
// - Soft reset ignored outside normal and stop.
// - Duty choices 20, 10, 5, 2.5 percent.
// - Pins start in the fail role after reset.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module sfo_supervisor import sfo_pkg::*; #(
  parameter int unsigned BLINK_HALF_CYC = BLINK_PERIOD_NS / 2 / CLK_NS,
  parameter int unsigned PWM_CYC = PWM_PERIOD_NS / CLK_NS,
  parameter int unsigned TEST_CYC = cyc_ceil(TEST_FILTER_NS),
  parameter int unsigned RD_CYC = cyc_ceil(RESET_DELAY_NS),
  parameter int unsigned RF_CYC = cyc_ceil(RESET_FILTER_NS)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sfo_mode_e sbc_mode,
  input wire logic failure_event,
  input wire logic fail_clear,
  input wire logic wd_fail_event,
  input wire logic vcc1_low,
  input wire logic blinking_fail_out_i,
  input wire logic dimmed_fail_test_pin_i,
  output logic static_fail_out_o,
  output logic static_fail_out_oe,
  output logic blinking_fail_out_o,
  output logic blinking_fail_out_oe,
  output logic dimmed_fail_test_pin_o,
  output logic dimmed_fail_test_pin_oe,
  output logic reset_out_pin_n,
  output logic [1:0] wake_event,
  output logic test_level,
  output logic soft_reset_req,
  output logic [1:0] reset_thr_sel
);

  // ==========================================================================
  // APB slave and registers
  logic [2:0] gpio_blink;
  logic [2:0] gpio_dim;
  logic [1:0] pulse_duty_select;
  logic soft_reset_pulse_select;
  logic [2:0] next_gpio_blink;
  logic [2:0] next_gpio_dim;
  logic [1:0] next_pulse_duty_select;
  logic next_soft_reset_pulse_select;
  logic [1:0] next_reset_thr_sel;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic next_soft_reset_req;
  logic soft_pulse;
  logic next_soft_pulse;
  logic acc;
  logic wr;
  logic fail_act;
  logic mapped;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign mapped = (paddr == ADDR_MODE) | (paddr == ADDR_GPIO) |
                  (paddr == ADDR_OPT) | (paddr == ADDR_STAT);

  always_comb begin
    next_gpio_blink = gpio_blink;
    next_gpio_dim = gpio_dim;
    next_pulse_duty_select = pulse_duty_select;
    next_soft_reset_pulse_select = soft_reset_pulse_select;
    next_reset_thr_sel = reset_thr_sel;
    next_soft_reset_req = 1'h0;
    next_soft_pulse = 1'h0;
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~mapped;
    next_prdata = 32'h0;
    if (psel & penable & ~pready) begin
      unique case (paddr)
        ADDR_GPIO: begin
          next_prdata[GPIO_BLINK_LSB +: 3] = gpio_blink;
          next_prdata[GPIO_DIM_LSB +: 3] = gpio_dim;
        end
        ADDR_OPT: begin
          next_prdata[OPT_DUTY_LSB +: 2] = pulse_duty_select;
          next_prdata[OPT_SOFT_BIT] = soft_reset_pulse_select;
          next_prdata[OPT_THR_LSB +: 2] = reset_thr_sel;
        end
        ADDR_STAT: begin
          next_prdata[STAT_MODE_LSB +: 3] = sbc_mode;
          next_prdata[STAT_RO_BIT] = reset_out_pin_n;
          next_prdata[STAT_TEST_BIT] = test_level;
          next_prdata[STAT_FAIL_BIT] = fail_act;
        end
        default: next_prdata = 32'h0;
      endcase
    end
    // Settings are written only in normal mode; sleep keeps them, stop keeps them until a soft reset restores defaults.
    if (wr && sbc_mode == MODE_NORMAL) begin
      if (paddr == ADDR_GPIO) begin
        next_gpio_blink = pwdata[GPIO_BLINK_LSB +: 3];
        next_gpio_dim = pwdata[GPIO_DIM_LSB +: 3];
      end
      if (paddr == ADDR_OPT) begin
        next_pulse_duty_select = pwdata[OPT_DUTY_LSB +: 2];
        next_soft_reset_pulse_select = pwdata[OPT_SOFT_BIT];
        next_reset_thr_sel = pwdata[OPT_THR_LSB +: 2];
      end
    end
    if (wr && paddr == ADDR_MODE && pwdata[MODE_LSB +: 2] == SOFT_RESET_CODE &&
        (sbc_mode == MODE_NORMAL || sbc_mode == MODE_STOP)) begin
      next_soft_reset_req = 1'h1;
      next_soft_pulse = ~soft_reset_pulse_select;
      next_gpio_blink = GPIO_RESET;
      next_gpio_dim = GPIO_RESET;
      next_pulse_duty_select = DUTY_RESET;
      next_soft_reset_pulse_select = SOFT_SEL_RESET;
      next_reset_thr_sel = THR_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gpio_blink <= GPIO_RESET;
      gpio_dim <= GPIO_RESET;
      pulse_duty_select <= DUTY_RESET;
      soft_reset_pulse_select <= SOFT_SEL_RESET;
      reset_thr_sel <= THR_RESET;
      soft_reset_req <= 1'h0;
      soft_pulse <= 1'h0;
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0;
    end else begin
      gpio_blink <= next_gpio_blink;
      gpio_dim <= next_gpio_dim;
      pulse_duty_select <= next_pulse_duty_select;
      soft_reset_pulse_select <= next_soft_reset_pulse_select;
      reset_thr_sel <= next_reset_thr_sel;
      soft_reset_req <= next_soft_reset_req;
      soft_pulse <= next_soft_pulse;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Failure latch and patterns
  logic next_fail_act;
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink_ph;
  logic next_blink_ph;
  logic [31:0] pwm_cnt;
  logic [31:0] next_pwm_cnt;
  logic dim_on;

  always_comb begin
    // A failure in the same cycle as a clear keeps the output active.
    next_fail_act = (fail_act & ~(fail_clear & sbc_mode == MODE_NORMAL)) |
                    failure_event;
    next_blink_cnt = 32'h0;
    next_blink_ph = 1'h1;
    next_pwm_cnt = 32'h0;
    if (fail_act) begin
      next_blink_ph = blink_ph;
      if (blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
        next_blink_ph = ~blink_ph;
      end else begin
        next_blink_cnt = blink_cnt + 32'h1;
      end
      if (pwm_cnt != 32'(PWM_CYC - 1)) begin
        next_pwm_cnt = pwm_cnt + 32'h1;
      end
    end
  end

  assign dim_on = pwm_cnt < 32'(PWM_CYC * duty_pm(pulse_duty_select) / PERMILLE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fail_act <= 1'h0;
      blink_cnt <= 32'h0;
      blink_ph <= 1'h1;
      pwm_cnt <= 32'h0;
    end else begin
      fail_act <= next_fail_act;
      blink_cnt <= next_blink_cnt;
      blink_ph <= next_blink_ph;
      pwm_cnt <= next_pwm_cnt;
    end
  end

  // ==========================================================================
  // Pin drivers and wake detection
  logic [1:0] next_blink_pin;
  logic [1:0] next_dim_pin;
  logic [1:0] next_wake_event;
  logic prev_blink_in;
  logic prev_dim_in;

  // Returns output enable and output level for one shared pin.
  function automatic logic [1:0] pin_drive(input logic [2:0] cfg,
                                           input sfo_mode_e mode,
                                           input logic act,
                                           input logic pat);
    logic sw_ok;
    sw_ok = (mode != MODE_RESTART) && (mode != MODE_FAILSAFE);
    unique case (cfg)
      CFG_FAIL: pin_drive = {act & pat, 1'h0};
      CFG_LOW: pin_drive = {sw_ok, 1'h0};
      CFG_HIGH: pin_drive = {sw_ok, 1'h1};
      default: pin_drive = 2'h0;
    endcase
  endfunction

  always_comb begin
    next_blink_pin = pin_drive(gpio_blink, sbc_mode, fail_act, blink_ph);
    next_dim_pin = pin_drive(gpio_dim, sbc_mode, fail_act, dim_on);
    next_wake_event = 2'h0;
    if (gpio_blink == CFG_WAKE && sbc_mode != MODE_FAILSAFE) begin
      next_wake_event[0] = blinking_fail_out_i != prev_blink_in;
    end
    if (gpio_dim == CFG_WAKE && sbc_mode != MODE_FAILSAFE) begin
      next_wake_event[1] = dimmed_fail_test_pin_i != prev_dim_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      static_fail_out_o <= 1'h0;
      static_fail_out_oe <= 1'h0;
      blinking_fail_out_oe <= 1'h0;
      blinking_fail_out_o <= 1'h0;
      dimmed_fail_test_pin_oe <= 1'h0;
      dimmed_fail_test_pin_o <= 1'h0;
      wake_event <= 2'h0;
      prev_blink_in <= 1'h1;
      prev_dim_in <= 1'h1;
    end else begin
      static_fail_out_o <= 1'h0;
      static_fail_out_oe <= fail_act;
      {blinking_fail_out_oe, blinking_fail_out_o} <= next_blink_pin;
      {dimmed_fail_test_pin_oe, dimmed_fail_test_pin_o} <= next_dim_pin;
      wake_event <= next_wake_event;
      prev_blink_in <= blinking_fail_out_i;
      prev_dim_in <= dimmed_fail_test_pin_i;
    end
  end

  // ==========================================================================
  // Test level sampling
  // The pin idles high through the board pull-up, so the filter starts high.
  sfo_filter #(.CYC(TEST_CYC), .INIT(1'h1)) u_test_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(dimmed_fail_test_pin_i),
    .level(test_level)
  );

  // ==========================================================================
  // Reset output
  logic uv_filt;
  logic ro_cause;
  logic [31:0] rd_cnt;
  logic [31:0] next_rd_cnt;
  logic next_reset_out_pin_n;

  // Filter starts high: at power-up the supply is assumed low until seen good.
  sfo_filter #(.CYC(RF_CYC), .INIT(1'h1)) u_uv_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(vcc1_low),
    .level(uv_filt)
  );

  assign ro_cause = uv_filt | wd_fail_event |
                    soft_pulse;

  always_comb begin
    next_rd_cnt = 32'h0;
    next_reset_out_pin_n = reset_out_pin_n;
    if (ro_cause) begin
      next_reset_out_pin_n = 1'h0;
    end else if (!reset_out_pin_n) begin
      if (rd_cnt == 32'(RD_CYC - 1)) begin
        next_reset_out_pin_n = 1'h1;
      end else begin
        next_rd_cnt = rd_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_out_pin_n <= 1'h0;
      rd_cnt <= 32'h0;
    end else begin
      reset_out_pin_n <= next_reset_out_pin_n;
      rd_cnt <= next_rd_cnt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  cfg_lock_a: assert property (
    wr && paddr == ADDR_GPIO && sbc_mode != MODE_NORMAL
    |=> $stable(gpio_blink) && $stable(gpio_dim))
    else $error("pin role changed outside normal mode");
  fail_activate_a: assert property (
    failure_event |=> ##1 static_fail_out_oe)
    else $error("static fail output not active after failure");
  wake_off_a: assert property (
    sbc_mode == MODE_FAILSAFE |=> wake_event == 2'h0)
    else $error("wake reported in fail-safe mode");
  switch_off_a: assert property (
    gpio_dim == CFG_HIGH && sbc_mode == MODE_RESTART |=> !dimmed_fail_test_pin_oe)
    else $error("switch driven in restart mode");
  fail_hold_a: assert property (
    fail_act && !(fail_clear && sbc_mode == MODE_NORMAL) |=> fail_act)
    else $error("fail output dropped without clear");
  blink_toggle_a: assert property (
    fail_act && $past(fail_act) && blink_ph != $past(blink_ph)
    |-> $past(blink_cnt) == 32'(BLINK_HALF_CYC - 1))
    else $error("blink phase toggled at wrong count");
  test_filter_a: assert property (
    $changed(test_level)
    |-> $past(dimmed_fail_test_pin_i, 1) == test_level &&
        $past(dimmed_fail_test_pin_i, 2) == test_level)
    else $error("test level accepted without steady input");
  wd_reset_a: assert property (
    wd_fail_event |=> !reset_out_pin_n ##1 !reset_out_pin_n)
    else $error("reset output not asserted on watchdog failure");
  soft_ignore_a: assert property (
    wr && paddr == ADDR_MODE && sbc_mode == MODE_SLEEP |=> !soft_reset_req)
    else $error("soft reset taken in sleep mode");
  soft_quiet_a: assert property (
    reset_out_pin_n && !uv_filt && $past(soft_reset_pulse_select) && soft_reset_req
    && !wd_fail_event |=> reset_out_pin_n)
    else $error("reset output pulsed with pulse option off");
  soft_cover_c: cover property (soft_reset_req ##1 !reset_out_pin_n);
  fail_cover_c: cover property (failure_event ##2 static_fail_out_oe);
  release_cover_c: cover property (!reset_out_pin_n ##1 reset_out_pin_n);
endmodule // sfo_supervisor

/* File: hw/sfo_pkg.sv */
// Purpose: Shared constants and types for the fail output and reset supervisor.
// Assumes: 250 MHz system clock, APB register access with 32-bit data.
// Notes: Times are kept in ns; cycle counts are derived in the top module.
package sfo_pkg;

  // ==========================================================================
  // Chip modes and pin roles
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } sfo_mode_e;

  // Codes 5 to 7 are illegal and behave as an unused pin.
  typedef enum logic [2:0] {
    CFG_FAIL, CFG_OFF, CFG_WAKE, CFG_LOW, CFG_HIGH
  } sfo_cfg_e;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_GPIO = 8'h04;
  localparam logic [7:0] ADDR_OPT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  localparam int MODE_LSB = 0;
  localparam logic [1:0] SOFT_RESET_CODE = 2'h3;
  localparam int GPIO_BLINK_LSB = 0;
  localparam int GPIO_DIM_LSB = 4;
  localparam int OPT_DUTY_LSB = 0;
  localparam int OPT_SOFT_BIT = 2;
  localparam int OPT_THR_LSB = 4;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_RO_BIT = 4;
  localparam int STAT_TEST_BIT = 5;
  localparam int STAT_FAIL_BIT = 6;

  localparam logic [2:0] GPIO_RESET = 3'h0;
  localparam logic [1:0] DUTY_RESET = 2'h0;
  localparam logic SOFT_SEL_RESET = 1'h0;
  localparam logic [1:0] THR_RESET = 2'h0;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned BLINK_PERIOD_NS = 800_000_000;
  localparam int unsigned PWM_PERIOD_NS = 10_000_000;
  localparam int unsigned TEST_FILTER_NS = 64_000;
  localparam int unsigned RESET_DELAY_NS = 10_000_000;
  localparam int unsigned RESET_FILTER_NS = 10_000;
  localparam int unsigned PERMILLE = 1000;

  // Pulse train duty in permille for select codes 0 to 3.
  function automatic int unsigned duty_pm(input logic [1:0] sel);
    unique case (sel)
      2'h0: duty_pm = 200;
      2'h1: duty_pm = 100;
      2'h2: duty_pm = 50;
      2'h3: duty_pm = 25;
    endcase
  endfunction

  function automatic int unsigned cyc_ceil(input int unsigned ns);
    cyc_ceil = (ns + CLK_NS - 1) / CLK_NS;
  endfunction

endpackage

/* File: hw/sfo_filter.sv */
// Purpose: Level filter that accepts a new input level once it held steadily.
// Assumes: Input is synchronous to clk_sys.
// Notes: Any glitch restarts the count, so short spikes never pass.
module sfo_filter import sfo_pkg::*; #(
  parameter int unsigned CYC = 16,
  parameter logic INIT = 1'h1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic raw,
  output logic level
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_level;

  // ==========================================================================
  // Filter
  always_comb begin
    next_cnt = 32'h0;
    next_level = level;
    if (raw != level) begin
      if (cnt == 32'(CYC - 1)) begin
        next_level = raw;
      end else begin
        next_cnt = cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 32'h0;
      level <= INIT;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
    end
  end

endmodule // sfo_filter

/* File: test/sfo_host_model.sv */
// Purpose: Host side register master for the supervisor block.
// Assumes: One clock; every signal changes by NBA right after a rising edge.
// Notes: With slow set, a second idle cycle precedes each setup cycle.
module sfo_host_model import sfo_pkg::*; (
  input wire logic clk_sys,
  input wire logic slow,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================================
  // Transfer
  // Released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    if (slow) @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // sfo_host_model

/* File: test/sfo_supervisor_tb_top.sv */
// Purpose: Self-checking bench for the fail output and reset supervisor.
// Assumes: Shortened counts; host model issues all register transfers.
// Notes: Pin levels resolve from enables; released pins read the bench level.
module sfo_supervisor_tb_top import sfo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BH = 8;
  localparam int PW = 40;
  localparam int TC = 4;
  localparam int RD = 6;
  localparam int RF = 3;
  typedef struct {
    sfo_mode_e m;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic err;
  } sfo_row_s;
  logic clk_sys, rst, slow, failure_event, fail_clear, wd_fail_event, vcc1_low;
  logic ext_blink, ext_dim, blink_pin, dim_pin, err;
  logic psel, penable, pwrite, pready, pslverr, static_fail_out_o, static_fail_out_oe;
  logic blinking_fail_out_o, blinking_fail_out_oe, dimmed_fail_test_pin_o;
  logic dimmed_fail_test_pin_oe, reset_out_pin_n, test_level, soft_reset_req;
  logic [1:0] wake_event, reset_thr_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sfo_mode_e mode;
  int error_cnt, checks, wk0, srq, n, s0, b, d;
  int pm [4] = '{200, 100, 50, 25};
  sfo_mode_e bad [4] = '{MODE_INIT, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
  sfo_mode_e sw_m [5] = '{MODE_RESTART, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_FAILSAFE};
  sfo_mode_e wk_m [4] = '{MODE_RESTART, MODE_FAILSAFE, MODE_NORMAL, MODE_STOP};
  sfo_row_s rows [6] = '{
    '{MODE_NORMAL, ADDR_GPIO, 32'h0000_0021, 32'h0000_0021, 1'b0},
    '{MODE_STOP, ADDR_GPIO, 32'h0000_0044, 32'h0000_0021, 1'b0},
    '{MODE_SLEEP, ADDR_OPT, 32'h0000_0037, 32'h0000_0000, 1'b0},
    '{MODE_STOP, ADDR_STAT, 32'h0000_00ff, 32'h0000_0032, 1'b0},
    '{MODE_NORMAL, ADDR_OPT, 32'h0000_0037, 32'h0000_0037, 1'b0},
    '{MODE_NORMAL, 8'h10, 32'h0000_0055, 32'h0000_0000, 1'b1}};

  assign blink_pin = blinking_fail_out_oe ? blinking_fail_out_o : ext_blink;
  assign dim_pin = dimmed_fail_test_pin_oe ? dimmed_fail_test_pin_o : ext_dim;

  sfo_supervisor #(.BLINK_HALF_CYC(BH), .PWM_CYC(PW), .TEST_CYC(TC), .RD_CYC(RD),
    .RF_CYC(RF)) DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sbc_mode(mode), .failure_event(failure_event),
    .fail_clear(fail_clear), .wd_fail_event(wd_fail_event), .vcc1_low(vcc1_low),
    .blinking_fail_out_i(blink_pin), .dimmed_fail_test_pin_i(dim_pin),
    .static_fail_out_o(static_fail_out_o), .static_fail_out_oe(static_fail_out_oe),
    .blinking_fail_out_o(blinking_fail_out_o), .blinking_fail_out_oe(blinking_fail_out_oe),
    .dimmed_fail_test_pin_o(dimmed_fail_test_pin_o),
    .dimmed_fail_test_pin_oe(dimmed_fail_test_pin_oe), .reset_out_pin_n(reset_out_pin_n),
    .wake_event(wake_event), .test_level(test_level), .soft_reset_req(soft_reset_req),
    .reset_thr_sel(reset_thr_sel));

  sfo_host_model host (.clk_sys(clk_sys), .slow(slow), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ==========================================================================
  // Clock, monitors and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    wk0 <= wk0 + int'(wake_event[0] === 1'b1) + int'(wake_event[1] === 1'b1);
    if (soft_reset_req === 1'b1) srq <= srq + 1;
  end
  initial begin
    #100us;
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    give_verdict();
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_in(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic set_mode(input sfo_mode_e m);
    @(posedge clk_sys);
    mode <= m;
    cyc(3);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, rd, err);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd, err);
  endtask
  // Waits for the reset output to rise; the watchdog ends a hang.
  task automatic wait_high(output int k);
    k = 0;
    while (reset_out_pin_n !== 1'b1) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  task automatic pulse_fail();
    @(posedge clk_sys);
    failure_event <= 1'b1;
    @(posedge clk_sys);
    failure_event <= 1'b0;
  endtask
  task automatic clear_fail();
    @(posedge clk_sys);
    fail_clear <= 1'b1;
    @(posedge clk_sys);
    fail_clear <= 1'b0;
    cyc(3);
  endtask
  task automatic count(input int len, output int bo, output int do_);
    bo = 0;
    do_ = 0;
    repeat (len) begin
      @(posedge clk_sys);
      bo += int'(blinking_fail_out_oe === 1'b1);
      do_ += int'(dimmed_fail_test_pin_oe === 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    mode = MODE_INIT;
    slow = 1'b0;
    failure_event = 1'b0;
    fail_clear = 1'b0;
    wd_fail_event = 1'b0;
    vcc1_low = 1'b1;
    ext_blink = 1'b1;
    ext_dim = 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    chk(32'(reset_out_pin_n), 32'h0);
    chk(32'(reset_thr_sel), 32'h0);
    chk(32'({static_fail_out_oe, blinking_fail_out_oe, dimmed_fail_test_pin_oe}), 0);
    vcc1_low <= 1'b0;
    wait_high(n);
    chk_in(n, RD, RF + RD + 3);
    vcc1_low <= 1'b1;
    cyc(1);
    vcc1_low <= 1'b0;
    cyc(8);
    chk(32'(reset_out_pin_n), 32'h1);
    vcc1_low <= 1'b1;
    cyc(RF + 13);
    chk(32'(reset_out_pin_n), 32'h0);
    vcc1_low <= 1'b0;
    wait_high(n);
    chk_in(n, RD, RF + RD + 3);
    wd_fail_event <= 1'b1;
    cyc(1);
    wd_fail_event <= 1'b0;
    cyc(1);
    chk(32'(reset_out_pin_n), 32'h0);
    wait_high(n);
    chk_in(n, RD - 1, RD + 3);
    $display("reset output tests done");
    foreach (rows[i]) begin
      set_mode(rows[i].m);
      slow <= i[0];
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      chk(rd, rows[i].exp);
      chk({31'h0, err}, {31'h0, rows[i].err});
    end
    chk(32'(reset_thr_sel), 32'h3);
    $display("register rows done");
    s0 = srq;
    wr_reg(ADDR_MODE, 32'h0000_0003);
    repeat (8) begin
      cyc(1);
      chk(32'(reset_out_pin_n), 32'h1);
    end
    chk(32'(srq - s0), 32'h1);
    rd_reg(ADDR_OPT);
    chk(rd, 32'h0);
    rd_reg(ADDR_GPIO);
    chk(rd, 32'h0);
    chk(32'(reset_thr_sel), 32'h0);
    set_mode(MODE_STOP);
    s0 = srq;
    wr_reg(ADDR_MODE, 32'h0000_0003);
    cyc(3);
    chk(32'(srq - s0), 32'h1);
    chk(32'(reset_out_pin_n), 32'h0);
    wait_high(n);
    chk_in(n, RD - 3, RD + 3);
    foreach (bad[i]) begin
      set_mode(bad[i]);
      s0 = srq;
      wr_reg(ADDR_MODE, 32'h0000_0003);
      cyc(3);
      chk(32'(srq - s0), 32'h0);
      chk(32'(reset_out_pin_n), 32'h1);
    end
    $display("soft reset tests done");
    set_mode(MODE_NORMAL);
    pulse_fail();
    set_mode(MODE_RESTART);
    chk(32'({static_fail_out_oe, static_fail_out_o}), 32'h2);
    count(10 * BH, b, d);
    chk(32'(b), 32'(5 * BH));
    chk(32'(d), 32'(2 * PW * 200 / 1000));
    set_mode(MODE_FAILSAFE);
    chk(32'(static_fail_out_oe), 32'h1);
    set_mode(MODE_NORMAL);
    chk(32'(static_fail_out_oe), 32'h1);
    rd_reg(ADDR_GPIO);
    chk(rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr_reg(ADDR_OPT, 32'(k));
      cyc(PW);
      count(2 * PW, b, d);
      chk(32'(d), 32'(2 * PW * pm[k] / 1000));
    end
    clear_fail();
    chk(32'({static_fail_out_oe, blinking_fail_out_oe, dimmed_fail_test_pin_oe}), 0);
    $display("fail pattern tests done");
    wr_reg(ADDR_GPIO, 32'h0000_0043);
    cyc(3);
    chk(32'({blinking_fail_out_oe, blinking_fail_out_o, dimmed_fail_test_pin_oe,
             dimmed_fail_test_pin_o}), 32'hb);
    foreach (sw_m[i]) begin
      set_mode(sw_m[i]);
      chk(32'({blinking_fail_out_oe, dimmed_fail_test_pin_oe}),
          (i % 4 == 0) ? 0 : 3);
    end
    set_mode(MODE_NORMAL);
    wr_reg(ADDR_GPIO, 32'h0000_0022);
    // Both pins toggle, so each mode that keeps wake capability counts two events.
    foreach (wk_m[i]) begin
      set_mode(wk_m[i]);
      s0 = wk0;
      ext_blink <= ~ext_blink;
      ext_dim <= ~ext_dim;
      cyc(4);
      chk(32'(wk0 - s0), (i == 1) ? 0 : 2);
    end
    $display("pin role tests done");
    set_mode(MODE_NORMAL);
    wr_reg(ADDR_GPIO, 32'h0000_0011);
    pulse_fail();
    set_mode(MODE_RESTART);
    s0 = wk0;
    ext_blink <= ~ext_blink;
    cyc(4);
    chk(32'({blinking_fail_out_oe, dimmed_fail_test_pin_oe, static_fail_out_oe}), 1);
    chk(32'(wk0 - s0), 32'h0);
    set_mode(MODE_NORMAL);
    clear_fail();
    ext_dim <= 1'b0;
    cyc(2);
    ext_dim <= 1'b1;
    cyc(TC + 4);
    chk(32'(test_level), 32'h1);
    ext_dim <= 1'b0;
    cyc(2);
    chk(32'(test_level), 32'h1);
    cyc(TC + 2);
    chk(32'(test_level), 32'h0);
    ext_dim <= 1'b1;
    cyc(TC + 4);
    $display("off role and test level tests done");
    give_verdict();
  end
endmodule // sfo_supervisor_tb_top
